// file: design/esc_clock_gate.sv
/*
  Glitch-free clock gate: the enable is latched while the clock is low.
  Assumes the enable comes from logic on the same clock.
*/
module esc_clock_gate (
  input wire logic core_clk,
  input wire logic enable,
  output logic gatedClk
);
  logic enableLatched;

  // latch transparent while clock low, so the gate never clips a high phase
  always_latch begin
    if (!core_clk) begin
      enableLatched = enable;
    end
  end

  assign gatedClk = core_clk & enableLatched;
endmodule

// file: design/esc_pkg.sv
/*
  Package for the Ethernet system control block: register offsets, field positions,
  reset values and clock enable codes.
  Assumes a 32-bit classic Wishbone slave with byte addressing.
*/
package esc_pkg;
  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_CLKG = 4'h4;
  localparam int ADDR_W = 4;

  // --------------------------------------------------------------------------
  // mode select fields
  // --------------------------------------------------------------------------
  localparam int MODE_PULSE_BIT = 28;
  localparam int MODE_CHANNEL1_RESET_CONTROL_BIT = 9;
  localparam int MODE_CHANNEL0_RESET_CONTROL_BIT = 8;
  localparam int MODE_IF_BIT = 0;
  localparam logic [31:0] MODE_WMASK = 32'h1000_0301;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  // --------------------------------------------------------------------------
  // clock gating fields
  // --------------------------------------------------------------------------
  localparam logic [31:0] CLKG_WMASK = 32'h0000_0003;
  localparam logic [1:0] CLKEN_OFF = 2'h0;
  localparam logic [1:0] CLKEN_CH0 = 2'h1;
  localparam logic [1:0] CLKEN_BOTH = 2'h3;
  localparam logic [1:0] CLKEN_RESET = 2'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // slave answer states
  typedef enum logic [1:0] {
    ESC_IDLE = 2'h0,
    ESC_ACK = 2'h1
  } esc_bus_state_t;
endpackage

// file: design/esc_sync.sv
/*
  Two-stage synchroniser for one level signal from another clock domain.
  Assumes the input is a level that stays long enough to be seen.
*/
module esc_sync (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic asyncIn,
  output logic syncOut
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } esc_sync_state_t;

  esc_sync_state_t state;
  esc_sync_state_t next_state;

  // first stage is read only by the second stage
  always_comb begin
    next_state = state;
    next_state.stage1 = asyncIn;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign syncOut = state.stage2;
endmodule

// file: design/esc_system_control.sv
/*
  Ethernet system control: mode select and clock gating registers behind a
  classic Wishbone slave; drives MAC reset, interface mode, pulse select and
  gated clocks for two MAC channels.
  Assumes MAC pulse outputs come from another clock domain and are synchronised here.
*/
module esc_system_control (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [esc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic macPulse0,
  input wire logic macPulse1,
  output logic shared_pulse_pin,
  output logic channel0_mac_reset,
  output logic channel1_mac_reset,
  output logic phy_interface_select,
  output logic pulse_output_select,
  output logic [1:0] mac_clock_enable,
  output logic mac0_clk,
  output logic mac1_clk
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    esc_pkg::esc_bus_state_t busState;
    logic ack;
    logic [31:0] readData;
    logic [31:0] modeReg;
    logic [1:0] clkEn;
    logic pulseOut;
  } esc_state_t;

  esc_state_t state;
  esc_state_t next_state;
  logic pulse0Sync;
  logic pulse1Sync;
  logic [31:0] byteMask;
  logic [31:0] modeWrite;
  logic [31:0] clkgWrite;
  logic [31:0] modeRead;
  logic [31:0] clkgRead;
  logic takeReq;
  logic modeWriteTaken;
  logic clkgWriteTaken;

  // --------------------------------------------------------------------------
  // pulse input synchronisers
  // --------------------------------------------------------------------------
  // the MAC time counter runs on its own clock, so each pulse is synchronised
  esc_sync u_sync0 (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn(macPulse0),
    .syncOut(pulse0Sync)
  );

  esc_sync u_sync1 (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn(macPulse1),
    .syncOut(pulse1Sync)
  );

  // --------------------------------------------------------------------------
  // write data with byte lanes
  // --------------------------------------------------------------------------
  // expand byte selects into a bit mask, one lane per generate pass
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign byteMask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
  end

  // reserved bits are forced to zero whatever software writes
  assign modeWrite = (state.modeReg & ~(byteMask & esc_pkg::MODE_WMASK))
                   | (wb_dat_i & byteMask & esc_pkg::MODE_WMASK);
  assign clkgWrite = ({30'h0000_0000, state.clkEn} & ~(byteMask & esc_pkg::CLKG_WMASK))
                   | (wb_dat_i & byteMask & esc_pkg::CLKG_WMASK);

  // --------------------------------------------------------------------------
  // read data and request decode
  // --------------------------------------------------------------------------
  // reserved bits are masked on the way out as well as on the way in, so no
  // stored bit outside a field can ever reach the bus; the mode read uses the
  // same MODE_WMASK as the write, so widening that mask widens both
  assign modeRead = state.modeReg & esc_pkg::MODE_WMASK;
  assign clkgRead = {30'h0000_0000, state.clkEn};

  // a request is taken only from idle: a master still holding its request
  // while ack stands is not served twice
  assign takeReq = wb_cyc_i && wb_stb_i && (state.busState == esc_pkg::ESC_IDLE);
  assign modeWriteTaken = takeReq && wb_we_i && (wb_adr_i == esc_pkg::ADDR_MODE);
  assign clkgWriteTaken = takeReq && wb_we_i && (wb_adr_i == esc_pkg::ADDR_CLKG);

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  // ack comes one cycle after the request is seen, then drops for a cycle
  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    next_state.busState = esc_pkg::ESC_IDLE;
    // pulse pin follows the selected channel
    if (state.modeReg[esc_pkg::MODE_PULSE_BIT]) begin
      next_state.pulseOut = pulse1Sync;
    end else begin
      next_state.pulseOut = pulse0Sync;
    end
    // read data is loaded only when a request is taken, so it stands until the next one
    if (takeReq) begin
      next_state.ack = 1'b1;
      next_state.busState = esc_pkg::ESC_ACK;
      next_state.readData = esc_pkg::READ_ZERO;
      if (wb_we_i) begin
        case (wb_adr_i)
          esc_pkg::ADDR_MODE: begin
            next_state.modeReg = modeWrite;
          end
          esc_pkg::ADDR_CLKG: begin
            next_state.clkEn = clkgWrite[1:0];
          end
          default: begin
            next_state.readData = esc_pkg::READ_ZERO;
          end
        endcase
      end else begin
        case (wb_adr_i)
          esc_pkg::ADDR_MODE: begin
            next_state.readData = modeRead;
          end
          esc_pkg::ADDR_CLKG: begin
            next_state.readData = clkgRead;
          end
          default: begin
            next_state.readData = esc_pkg::READ_ZERO; // unmapped reads zero, still acked
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  // async reset clears every field, so both MAC clocks are stopped after reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{
        busState: esc_pkg::ESC_IDLE,
        ack: 1'b0,
        readData: esc_pkg::READ_ZERO,
        modeReg: esc_pkg::MODE_RESET,
        clkEn: esc_pkg::CLKEN_RESET,
        pulseOut: 1'b0
      };
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // each control output is a register bit, so it follows the write at once
  assign wb_ack_o = state.ack;
  assign wb_dat_o = state.readData;
  assign shared_pulse_pin = state.pulseOut;
  assign channel1_mac_reset = state.modeReg[esc_pkg::MODE_CHANNEL1_RESET_CONTROL_BIT];
  assign channel0_mac_reset = state.modeReg[esc_pkg::MODE_CHANNEL0_RESET_CONTROL_BIT];
  assign phy_interface_select = state.modeReg[esc_pkg::MODE_IF_BIT];
  assign pulse_output_select = state.modeReg[esc_pkg::MODE_PULSE_BIT];
  assign mac_clock_enable = state.clkEn;

  // --------------------------------------------------------------------------
  // clock gates
  // --------------------------------------------------------------------------
  // the gated clocks are combinational by nature; the latch keeps them clean
  esc_clock_gate u_gate0 (
    .core_clk(core_clk),
    .enable(state.clkEn[0]),
    .gatedClk(mac0_clk)
  );

  esc_clock_gate u_gate1 (
    .core_clk(core_clk),
    .enable(state.clkEn[1]), // 10 is not blocked by the write mask, so bit 1 alone runs mac1_clk
    .gatedClk(mac1_clk)
  );

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // handshake: each taken request earns exactly one ack, one cycle later,
  // and an idle bus never sees one
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack given without a request");

  // read data: reserved bits stay zero and writable bits mirror the outputs
  a_mode_reserved_zero: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == esc_pkg::ADDR_MODE
      |-> (wb_dat_o & ~esc_pkg::MODE_WMASK) == 32'h0000_0000)
    else $error("mode reserved bits read nonzero");
  a_mode_read_value: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == esc_pkg::ADDR_MODE
      |-> wb_dat_o[esc_pkg::MODE_PULSE_BIT] == pulse_output_select
        && wb_dat_o[esc_pkg::MODE_CHANNEL1_RESET_CONTROL_BIT] == channel1_mac_reset
        && wb_dat_o[esc_pkg::MODE_CHANNEL0_RESET_CONTROL_BIT] == channel0_mac_reset
        && wb_dat_o[esc_pkg::MODE_IF_BIT] == phy_interface_select)
    else $error("mode readback differs from the control outputs");
  a_clkg_reserved_zero: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == esc_pkg::ADDR_CLKG
      |-> wb_dat_o[31:2] == 30'h0000_0000)
    else $error("clock gating reserved bits nonzero");
  a_read_back: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == esc_pkg::ADDR_CLKG
      |-> wb_dat_o[1:0] == mac_clock_enable)
    else $error("clock enable readback wrong");
  a_unmapped_read_zero: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) != esc_pkg::ADDR_MODE
      && $past(wb_adr_i) != esc_pkg::ADDR_CLKG
      |-> wb_dat_o == esc_pkg::READ_ZERO)
    else $error("unmapped offset read nonzero");

  // writes: a taken write moves each selected field at the next edge
  a_channel0_reset_control_write: assert property (
    modeWriteTaken && wb_sel_i[1]
      |=> channel0_mac_reset == $past(wb_dat_i[esc_pkg::MODE_CHANNEL0_RESET_CONTROL_BIT]))
    else $error("channel 0 reset not following write");
  a_channel1_reset_control_write: assert property (
    modeWriteTaken && wb_sel_i[1]
      |=> channel1_mac_reset == $past(wb_dat_i[esc_pkg::MODE_CHANNEL1_RESET_CONTROL_BIT]))
    else $error("channel 1 reset not following write");
  a_if_write: assert property (
    modeWriteTaken && wb_sel_i[0]
      |=> phy_interface_select == $past(wb_dat_i[esc_pkg::MODE_IF_BIT]))
    else $error("interface select not following write");
  a_pulse_sel_write: assert property (
    modeWriteTaken && wb_sel_i[3]
      |=> pulse_output_select == $past(wb_dat_i[esc_pkg::MODE_PULSE_BIT]))
    else $error("pulse select not following write");
  a_clken_write: assert property (
    clkgWriteTaken && wb_sel_i[0]
      |=> mac_clock_enable == $past(wb_dat_i[1:0]))
    else $error("clock enable not following write");

  // holds: with no write taken a control output never moves, so an unmapped
  // write or a write to the other register leaves it alone; this is what
  // keeps a MAC from seeing a stray reset or clock stop
  a_channel0_reset_control_hold: assert property (
    !modeWriteTaken |=> $stable(channel0_mac_reset))
    else $error("channel 0 reset moved without a write");
  a_channel1_reset_control_hold: assert property (
    !modeWriteTaken |=> $stable(channel1_mac_reset))
    else $error("channel 1 reset moved without a write");
  a_if_hold: assert property (
    !modeWriteTaken |=> $stable(phy_interface_select))
    else $error("interface select moved without a write");
  a_pulse_sel_hold: assert property (
    !modeWriteTaken |=> $stable(pulse_output_select))
    else $error("pulse select moved without a write");
  a_clken_hold: assert property (
    !clkgWriteTaken |=> $stable(mac_clock_enable))
    else $error("clock enable moved without a write");

  // routing: the pin shows last cycle's synchronised pulse of the selected channel
  a_pulse_route: assert property (
    pulse_output_select == $past(pulse_output_select)
      |-> shared_pulse_pin == $past(pulse_output_select ? pulse1Sync : pulse0Sync))
    else $error("pulse pin not routed from selected channel");

  // main scenarios
  c_mode_write: cover property (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == esc_pkg::ADDR_MODE);
  c_both_clocks: cover property (mac_clock_enable == esc_pkg::CLKEN_BOTH);
  c_ch0_clock: cover property (mac_clock_enable == esc_pkg::CLKEN_CH0);
  c_pulse_ch1: cover property (pulse_output_select && shared_pulse_pin);
  c_rmii_mode: cover property (phy_interface_select);
endmodule

// file: testbench/esc_mac_model.sv
/*
  Behavioural model of one MAC channel on the far side of the system control block.
  Assumes its clock is the gated copy from the block and its reset the block's level output.
*/
module esc_mac_model (
  input wire logic macClk,
  input wire logic macReset,
  output logic macPulse,
  output int unsigned edgeCount
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------------
  // time pulse counter
  // ----------------------------------------------------------------------------
  logic [3:0] tick = 4'h0;

  // a stopped clock freezes the count, so the pulse stands still while gated off
  always @(posedge macClk or posedge macReset) begin
    if (macReset) begin
      tick <= 4'h0;
    end else begin
      tick <= tick + 4'h1;
    end
  end
  assign macPulse = tick[3]; // slow square wave, low while held in reset

  // edge counter lets the bench see whether the clock is supplied
  initial edgeCount = 0;
  always @(posedge macClk) begin
    edgeCount <= edgeCount + 1;
  end
endmodule

// file: testbench/tb_esc_system_control.sv
/*
  Self-checking bench for the Ethernet system control block: Wishbone register
  tasks, two MAC channel models and sequences of accesses with expected values.
  Assumes a 100 MHz core clock and the one-cycle ack of the slave.
*/
module tb_esc_system_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [esc_pkg::ADDR_W-1:0] wbAdr = '0;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0, wbDatOut, rdData;
  logic wbAck, macPulse0, macPulse1, sharedPin, channel0_reset_control, channel1_reset_control, ifSel, pulseSel, mac0Clk, mac1Clk, seen;
  logic [1:0] clkEn;
  int unsigned cnt0, cnt1, base0, base1;
  int n_errors = 0, n_checks = 0;
  logic [31:0] modeBits [4] = '{32'h1, 32'h100, 32'h200, 32'h1000_0000};
  logic [1:0] clkCodes [3] = '{esc_pkg::CLKEN_OFF, esc_pkg::CLKEN_CH0, esc_pkg::CLKEN_BOTH};

  always #5 core_clk = ~core_clk;

  esc_system_control uut (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatIn), .wb_dat_o(wbDatOut),
    .wb_ack_o(wbAck), .macPulse0(macPulse0), .macPulse1(macPulse1), .shared_pulse_pin(sharedPin),
    .channel0_mac_reset(channel0_reset_control), .channel1_mac_reset(channel1_reset_control), .phy_interface_select(ifSel),
    .pulse_output_select(pulseSel), .mac_clock_enable(clkEn), .mac0_clk(mac0Clk), .mac1_clk(mac1Clk));
  esc_mac_model mac0 (.macClk(mac0Clk), .macReset(channel0_reset_control), .macPulse(macPulse0), .edgeCount(cnt0));
  esc_mac_model mac1 (.macClk(mac1Clk), .macReset(channel1_reset_control), .macPulse(macPulse1), .edgeCount(cnt1));

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high at an edge, only the watchdog ends a hang
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] sel);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatIn <= wd;
    do begin
      @(posedge core_clk);
    end while (wbAck !== 1'b1);
    rdData = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
    wb(1'b1, adr, wd, 4'hF);
  endtask

  task automatic rdc(input logic [3:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, 4'hF);
    chk(rdData, exp);
  endtask

  // whether each MAC clock ticked over a span of 20 cycles
  task automatic clk_check(input logic [1:0] code);
    base0 = cnt0;
    base1 = cnt1;
    repeat (20) @(posedge core_clk);
    #1;
    chk({30'h0, (cnt1 - base1) > 15, (cnt0 - base0) > 15}, {30'h0, code});
  endtask

  // pulse pin watched for 40 cycles after the path has settled
  task automatic pulse_check(input logic [31:0] mode, input logic exp);
    wr(esc_pkg::ADDR_MODE, mode);
    repeat (4) @(posedge core_clk);
    seen = 1'b0;
    repeat (40) begin
      @(posedge core_clk);
      seen = seen | sharedPin;
    end
    chk({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    rdc(esc_pkg::ADDR_MODE, 32'h0);
    rdc(esc_pkg::ADDR_CLKG, 32'h0);
    chk({26'h0, clkEn, channel1_reset_control, channel0_reset_control, ifSel, pulseSel}, 32'h0);
    clk_check(2'h0);
    $display("test reset done");
    // reserved ones are dropped, writable fields read back and drive their pins
    wr(esc_pkg::ADDR_MODE, 32'hFFFF_FFFF);
    rdc(esc_pkg::ADDR_MODE, esc_pkg::MODE_WMASK);
    chk({28'h0, pulseSel, channel1_reset_control, channel0_reset_control, ifSel}, 32'hF);
    for (int i = 0; i < 4; i++) begin
      wr(esc_pkg::ADDR_MODE, modeBits[i]);
      rdc(esc_pkg::ADDR_MODE, modeBits[i]);
      chk({28'h0, pulseSel, channel1_reset_control, channel0_reset_control, ifSel}, 32'h1 << i);
    end
    // only lane 0 is written: the pulse select left set by the loop stays
    wb(1'b1, esc_pkg::ADDR_MODE, 32'hFFFF_FFFF, 4'h1);
    rdc(esc_pkg::ADDR_MODE, 32'h1000_0001);
    $display("test mode fields done");
    // clock codes, with reserved ones written alongside to prove they read back zero
    for (int i = 0; i < 3; i++) begin
      wr(esc_pkg::ADDR_CLKG, 32'hFFFF_FFFC | {30'h0, clkCodes[i]});
      rdc(esc_pkg::ADDR_CLKG, {30'h0, clkCodes[i]});
      chk({30'h0, clkEn}, {30'h0, clkCodes[i]});
      clk_check(clkCodes[i]);
    end
    $display("test clock gating done");
    // only a channel out of reset pulses, so the selected one decides what the pin shows
    pulse_check(32'h0000_0100, 1'b0);
    pulse_check(32'h1000_0100, 1'b1);
    pulse_check(32'h0000_0200, 1'b1);
    pulse_check(32'h1000_0200, 1'b0);
    $display("test pulse routing done");
    wr(4'h8, 32'hFFFF_FFFF);
    rdc(4'h8, 32'h0);
    rdc(esc_pkg::ADDR_MODE, 32'h1000_0200);
    rdc(esc_pkg::ADDR_CLKG, 32'h3);
    $display("test unmapped done");
    // a second reset in mid-run returns every field to its reset value
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rdc(esc_pkg::ADDR_MODE, 32'h0);
    rdc(esc_pkg::ADDR_CLKG, 32'h0);
    chk({26'h0, clkEn, channel1_reset_control, channel0_reset_control, ifSel, pulseSel}, 32'h0);
    clk_check(2'h0);
    $display("test second reset done");
    give_verdict();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    give_verdict();
  end
endmodule
